// ==== design/wcio_pkg.sv ====
// Shared constants and types for the weighing control connector block
package wcio_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INSEL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_FINAL = 8'h0c;
   localparam logic [7:0] OFS_SP1 = 8'h10;
   localparam logic [7:0] OFS_SP2 = 8'h14;
   localparam logic [7:0] OFS_CPS = 8'h18;
   localparam logic [7:0] OFS_NEARZERO = 8'h1c;
   localparam logic [7:0] OFS_UPPER = 8'h20;
   localparam logic [7:0] OFS_LOWER = 8'h24;
   localparam logic [7:0] OFS_DZRANGE = 8'h28;
   localparam logic [7:0] OFS_CAPACITY = 8'h2c;
   localparam logic [7:0] OFS_GROSS = 8'h30;
   localparam logic [7:0] OFS_NET = 8'h34;
   localparam logic [7:0] OFS_TARE = 8'h38;
   localparam logic [7:0] OFS_ACCVAL = 8'h3c;

   // CTRL field positions
   localparam int CTL_GN_LEVEL = 0;
   localparam int CTL_TARE_STABLE = 1;
   localparam int CTL_TARE_RANGE = 2;
   localparam int CTL_SEQ_MODE = 3;
   localparam int CTL_LIM_JUDGE = 4;
   localparam int CTL_EXT_FEED = 5;
   localparam int CTL_DISCHARGE = 6;
   localparam int CTL_ACC_NET = 7;
   localparam int CTL_UPPER_STRICT = 8;
   localparam int CTL_WIDTH = 9;

   // STATUS field positions; ST_ZERO_ALARM is write-1-to-clear
   localparam int ST_DISP_NET = 0;
   localparam int ST_TARE_ACT = 1;
   localparam int ST_ZERO_ALARM = 2;
   localparam int ST_HOLD = 3;
   localparam int ST_DISCH = 4;
   localparam int ST_JUDGE = 5;

   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [11:0] INSEL_RST = 12'h000;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int NUM_SEL = 4;
   localparam int FN_BITS = 3;

   // Functions of the selectable input pins
   typedef enum logic [2:0] {
      FN_HOLD = 3'h0,
      FN_ACC_CLR = 3'h1,
      FN_ACC_CMD = 3'h2,
      FN_STOP = 3'h3,
      FN_START = 3'h4,
      FN_FEED = 3'h5,
      FN_JUDGE = 3'h6
   } wcio_fn_t;

   // Contact inputs, 1 = contact closed to the common return
   typedef struct packed {
      logic gross_net;
      logic zero_req;
      logic tare_on;
      logic tare_off;
      logic [NUM_SEL-1:0] sel;
   } wcio_in_t;

   // Open-collector drives, 1 = transistor conducting
   typedef struct packed {
      logic near_zero;
      logic setpoint_one;
      logic setpoint_two;
      logic setpoint_three;
      logic lower_limit;
      logic upper_limit;
      logic stable_indicator;
      logic weight_error;
      logic sequence_error;
   } wcio_out_t;

   // Action strobes toward the weighing and statistics logic
   typedef struct packed {
      logic accum_cmd;
      logic accum_clear;
      logic seq_start;
      logic seq_stop;
   } wcio_evt_t;

endpackage

// ==== design/wcio_top.sv ====
// Control connector I/O of the weighing controller with AXI4-Lite registers
// What this block does
// - Each output bit 1 turns its open-collector transistor on, 0 off.
// - Edge mode: gross/net rise shows net, fall shows gross.
// - Level mode: net shown while gross/net active, gross otherwise.
// - Zero rise zeroes gross inside zero range, else raises zero alarm.
// - Tare rise subtracts tare; with restriction only while stable.
// - Tare allowed over full range or only for 0 < tare <= capacity.
// - Tare-reset rise cancels tare subtraction.
// - Hold freezes weight and comparisons, shows hold; none in sequence.
// - Judge acts only when configured external, ignored in sequence mode.
// - External feed select: inactive feeds, active discharges.
// - Accumulation rise accumulates gross or net as selected.
// - Accumulation-clear rise clears all accumulated data at once.
// - Each selectable pin takes one of seven functions by setting.
// - Duplicated non-hold function forced to hold; any hold pin holds.
// - Set points on when weight >= final minus set point or compensation.
// - Near-zero on when weight <= near-zero set value.
// - Lower on at or below lower; upper at or above, strict optional.
// - Limit comparison continuous or only while judging, by setting.
// - Stable output follows the motion detector.
// - Weight error on for load error, overflow or zero alarm.
// - Sequence error output follows the sequence error indication.
`timescale 1ns/1ns
module wcio_top
   import wcio_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Weighing datapath
   input wire logic signed [31:0] raw_weight,
   input wire logic motion_stable,
   input wire logic load_error,
   input wire logic overflow_error,
   input wire logic seq_error_ind,
   // Connector
   input wire wcio_in_t ctl_in,
   output wcio_out_t oc_drive,
   // Actions and modes
   output wcio_evt_t evt,
   output logic signed [31:0] accum_value,
   output logic hold_indicator,
   output logic discharge_mode
);

   logic [31:0] ctrl;
   logic [11:0] insel;
   logic signed [31:0] final_v, sp1_v, sp2_v, cps_v, nz_v;
   logic signed [31:0] upper_v, lower_v, dz_v, cap_v;
   logic signed [31:0] zero_ofs, tare, held_weight;
   logic disp_net, tare_act, zero_alarm;
   wcio_in_t sync1, sync2, prev;
   wcio_in_t rise;
   logic signed [31:0] gross, net, live_weight;
   wcio_fn_t eff [NUM_SEL];
   logic hold_lvl, judge_lvl, feed_lvl;
   logic acc_cmd_r, acc_clr_r, start_r, stop_r;
   logic zero_in_range, tare_allowed, hold_active, judge_active, lim_en;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write, zero_alarm_clr;

   // Pin function after the duplicate check
   function automatic wcio_fn_t pin_fn(input logic [11:0] sel, input int i);
      logic [2:0] f;
      logic dup;
      f = sel[i*FN_BITS +: FN_BITS];
      dup = 1'b0;
      for (int j = 0; j < NUM_SEL; j++) begin
         if (j != i && sel[j*FN_BITS +: FN_BITS] == f) begin
            dup = 1'b1;
         end
      end
      if (f > FN_JUDGE || (dup && f != FN_HOLD)) begin
         return FN_HOLD;
      end
      return wcio_fn_t'(f);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= OFS_ACCVAL;
   endfunction

   // Two-stage synchroniser then edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end else begin
         sync1 <= ctl_in;
         sync2 <= sync1;
         prev <= sync2;
      end
   end
   assign rise = sync2 & ~prev;

   always_comb begin
      hold_lvl = 1'b0;
      judge_lvl = 1'b0;
      feed_lvl = 1'b0;
      acc_cmd_r = 1'b0;
      acc_clr_r = 1'b0;
      start_r = 1'b0;
      stop_r = 1'b0;
      for (int i = 0; i < NUM_SEL; i++) begin
         eff[i] = pin_fn(insel, i);
         unique case (eff[i])
            FN_HOLD: hold_lvl = hold_lvl | sync2.sel[i];
            FN_JUDGE: judge_lvl = sync2.sel[i];
            FN_FEED: feed_lvl = sync2.sel[i];
            FN_ACC_CMD: acc_cmd_r = rise.sel[i];
            FN_ACC_CLR: acc_clr_r = rise.sel[i];
            FN_START: start_r = rise.sel[i];
            FN_STOP: stop_r = rise.sel[i];
         endcase
      end
   end

   assign gross = raw_weight - zero_ofs;
   assign net = tare_act ? gross - tare : gross;
   assign live_weight = disp_net ? net : gross;
   assign hold_active = hold_lvl & ~ctrl[CTL_SEQ_MODE];
   assign judge_active = judge_lvl & ~ctrl[CTL_SEQ_MODE];
   assign lim_en = ~ctrl[CTL_LIM_JUDGE] | judge_active;
   assign zero_in_range = gross <= dz_v && gross >= -dz_v;
   assign tare_allowed = (~ctrl[CTL_TARE_STABLE] | motion_stable) &
      (~ctrl[CTL_TARE_RANGE] | (gross > 0 && gross <= cap_v));

   // Gross/net display select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_net <= 1'b0;
      end else if (ctrl[CTL_GN_LEVEL]) begin
         disp_net <= sync2.gross_net;
      end else if (rise.gross_net) begin
         disp_net <= 1'b1;
      end else if (sync2.gross_net == 1'b0 && prev.gross_net) begin
         disp_net <= 1'b0;
      end
   end

   // Zeroing and zero alarm; a new failure wins over a software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         zero_ofs <= '0;
         zero_alarm <= 1'b0;
      end else if (rise.zero_req && zero_in_range) begin
         zero_ofs <= raw_weight;
         zero_alarm <= 1'b0;
      end else if (rise.zero_req) begin
         zero_alarm <= 1'b1;
      end else if (zero_alarm_clr) begin
         zero_alarm <= 1'b0;
      end
   end

   // Tare: tare-reset wins when both edges land together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tare <= '0;
         tare_act <= 1'b0;
      end else if (rise.tare_off) begin
         tare_act <= 1'b0;
      end else if (rise.tare_on && tare_allowed) begin
         tare <= gross;
         tare_act <= 1'b1;
      end
   end

   // Held weight and comparison outputs freeze together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held_weight <= '0;
         oc_drive <= '0;
      end else begin
         oc_drive.stable_indicator <= motion_stable;
         oc_drive.weight_error <= load_error | overflow_error | zero_alarm;
         oc_drive.sequence_error <= seq_error_ind;
         if (!hold_active) begin
            held_weight <= live_weight;
            oc_drive.near_zero <= live_weight <= nz_v;
            oc_drive.setpoint_one <= live_weight >= final_v - sp1_v;
            oc_drive.setpoint_two <= live_weight >= final_v - sp2_v;
            oc_drive.setpoint_three <= live_weight >= final_v - cps_v;
            oc_drive.lower_limit <= lim_en && live_weight <= lower_v;
            oc_drive.upper_limit <= lim_en && (ctrl[CTL_UPPER_STRICT] ?
               live_weight > upper_v : live_weight >= upper_v);
         end
      end
   end

   // Action strobes, one cycle each
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt <= '0;
         accum_value <= '0;
         discharge_mode <= 1'b0;
      end else begin
         evt.accum_cmd <= acc_cmd_r;
         evt.accum_clear <= acc_clr_r;
         evt.seq_start <= start_r;
         evt.seq_stop <= stop_r;
         if (acc_cmd_r) begin
            accum_value <= ctrl[CTL_ACC_NET] ? net : gross;
         end
         discharge_mode <= ctrl[CTL_EXT_FEED] ? feed_lvl :
            ctrl[CTL_DISCHARGE];
      end
   end
   assign hold_indicator = hold_active;

   // AXI4-Lite write path: address and data taken in either order
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   assign zero_alarm_clr = do_write && aw_addr == OFS_STATUS && w_strb[0] &&
      w_data[ST_ZERO_ALARM];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RST;
         insel <= INSEL_RST;
         final_v <= CFG_RST;
         sp1_v <= CFG_RST;
         sp2_v <= CFG_RST;
         cps_v <= CFG_RST;
         nz_v <= CFG_RST;
         upper_v <= CFG_RST;
         lower_v <= CFG_RST;
         dz_v <= CFG_RST;
         cap_v <= CFG_RST;
      end else if (do_write) begin
         unique case (aw_addr)
            OFS_CTRL: ctrl <= merge(ctrl, w_data, w_strb) &
               32'(2**CTL_WIDTH - 1);
            OFS_INSEL: insel <= 12'(merge({20'h0, insel}, w_data, w_strb));
            OFS_FINAL: final_v <= merge(final_v, w_data, w_strb);
            OFS_SP1: sp1_v <= merge(sp1_v, w_data, w_strb);
            OFS_SP2: sp2_v <= merge(sp2_v, w_data, w_strb);
            OFS_CPS: cps_v <= merge(cps_v, w_data, w_strb);
            OFS_NEARZERO: nz_v <= merge(nz_v, w_data, w_strb);
            OFS_UPPER: upper_v <= merge(upper_v, w_data, w_strb);
            OFS_LOWER: lower_v <= merge(lower_v, w_data, w_strb);
            OFS_DZRANGE: dz_v <= merge(dz_v, w_data, w_strb);
            OFS_CAPACITY: cap_v <= merge(cap_v, w_data, w_strb);
            default: ;
         endcase
      end
   end

   // AXI4-Lite read path: one cycle from address to data
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            OFS_CTRL: s_axi_rdata <= ctrl;
            OFS_INSEL: s_axi_rdata <= {20'h0, insel};
            OFS_STATUS: s_axi_rdata <= {26'h0, judge_active,
               discharge_mode, hold_active, zero_alarm, tare_act, disp_net};
            OFS_FINAL: s_axi_rdata <= final_v;
            OFS_SP1: s_axi_rdata <= sp1_v;
            OFS_SP2: s_axi_rdata <= sp2_v;
            OFS_CPS: s_axi_rdata <= cps_v;
            OFS_NEARZERO: s_axi_rdata <= nz_v;
            OFS_UPPER: s_axi_rdata <= upper_v;
            OFS_LOWER: s_axi_rdata <= lower_v;
            OFS_DZRANGE: s_axi_rdata <= dz_v;
            OFS_CAPACITY: s_axi_rdata <= cap_v;
            OFS_GROSS: s_axi_rdata <= gross;
            OFS_NET: s_axi_rdata <= held_weight;
            OFS_TARE: s_axi_rdata <= tare;
            OFS_ACCVAL: s_axi_rdata <= accum_value;
            default: s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_zero_taken: assert property (
      rise.zero_req && zero_in_range |=> zero_ofs == $past(raw_weight))
      else $error("zeroing inside range not applied");
   chk_zero_alarm: assert property (
      rise.zero_req && !zero_in_range |=> zero_alarm && $stable(zero_ofs))
      else $error("out-of-range zeroing not refused");
   chk_tare_stable: assert property (
      rise.tare_on && !rise.tare_off && ctrl[CTL_TARE_STABLE] &&
      !motion_stable |=> $stable(tare) && $stable(tare_act))
      else $error("tare taken while unstable");
   chk_tare_reset: assert property (
      rise.tare_off |=> !tare_act)
      else $error("tare reset ignored");
   chk_gn_edge: assert property (
      !ctrl[CTL_GN_LEVEL] && rise.gross_net ##1 !ctrl[CTL_GN_LEVEL]
      |-> disp_net)
      else $error("net not selected on rising edge");
   chk_gn_level: assert property (
      ctrl[CTL_GN_LEVEL] |=> disp_net == $past(sync2.gross_net))
      else $error("level mode display mismatch");
   chk_hold_freeze: assert property (
      hold_active |=> $stable(held_weight) && oc_drive.near_zero ==
      $past(oc_drive.near_zero) && oc_drive.upper_limit ==
      $past(oc_drive.upper_limit))
      else $error("hold did not freeze");
   chk_near_zero: assert property (
      !hold_active |=> oc_drive.near_zero == ($past(live_weight) <=
      $past(nz_v)))
      else $error("near-zero compare wrong");
   chk_wt_err: assert property (
      load_error |=> oc_drive.weight_error)
      else $error("weight error not raised");
   chk_edge_once: assert property (
      evt.accum_cmd |=> !evt.accum_cmd)
      else $error("accumulation strobe repeated");
   chk_dup_hold: assert property (
      insel[2:0] == insel[5:3] && insel[2:0] != FN_HOLD |->
      eff[0] == FN_HOLD && eff[1] == FN_HOLD)
      else $error("duplicate function not forced to hold");
   chk_axi_bresp: assert property (
      do_write && !mapped(aw_addr) |=> s_axi_bvalid &&
      s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");

   cov_zero_ok: cover property (rise.zero_req && zero_in_range);
   cov_tare: cover property (rise.tare_on && tare_allowed);
   cov_hold: cover property (hold_active [*3]);
   cov_accum: cover property (evt.accum_cmd);

endmodule

// ==== dv/wcio_contacts.sv ====
// Contact and relay side of the control connector, as seen by the bench
`timescale 1ns/1ns
module wcio_contacts
   import wcio_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Contact positions that the bench asks for
   input wire wcio_in_t contact_req,
   // Toward the device
   output wcio_in_t ctl_in,
   // Relay coils on the open-collector outputs
   input wire wcio_out_t oc_drive,
   output wcio_out_t relay_on
);
   // Contacts move right after an edge, like a PLC output scan
   always @(posedge aclk) begin
      ctl_in <= contact_req;
   end
   // A conducting transistor energises its relay coil
   assign relay_on = oc_drive;
endmodule

// ==== dv/wcio_top_tb.sv ====
// Self-checking bench for the weighing control connector block
`timescale 1ns/1ns
module wcio_top_tb;
   import wcio_pkg::*;
   typedef struct packed {
      logic signed [31:0] weight;
      logic [3:0] status_in;
      wcio_out_t expect_out;
   } wcio_row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0;
   logic [7:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
   logic [31:0] s_axi_rdata, rdat;
   logic signed [31:0] raw_weight = '0;
   logic signed [31:0] accum_value;
   logic motion_stable = 1'b0;
   logic load_error = 1'b0;
   logic overflow_error = 1'b0;
   logic seq_error_ind = 1'b0;
   logic hold_indicator, discharge_mode;
   wcio_in_t contact_req = '0;
   wcio_in_t ctl_in;
   wcio_out_t oc_drive, relay_on;
   wcio_evt_t evt;
   wcio_row_t rows [10];
   int n_errors = 0;
   int samples_checked = 0;
   int n_acc = 0;
   int n_clr = 0;
   int n_seq = 0;

   always #4 aclk = ~aclk;

   wcio_top dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .raw_weight(raw_weight),
      .motion_stable(motion_stable), .load_error(load_error),
      .overflow_error(overflow_error), .seq_error_ind(seq_error_ind),
      .ctl_in(ctl_in), .oc_drive(oc_drive), .evt(evt),
      .accum_value(accum_value), .hold_indicator(hold_indicator),
      .discharge_mode(discharge_mode));

   wcio_contacts partner_u (.aclk(aclk), .contact_req(contact_req),
      .ctl_in(ctl_in), .oc_drive(oc_drive), .relay_on(relay_on));

   // Pulses are counted so a doubled strobe shows up as a wrong count
   always @(posedge aclk) begin
      if (evt.accum_cmd === 1'b1) n_acc++;
      if (evt.accum_clear === 1'b1) n_clr++;
      if (evt.seq_start === 1'b1) n_seq++;
      if (evt.seq_stop === 1'b1) n_seq += 16;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // No handshake on the connector path; six edges cover sync plus output
   task automatic settle();
      repeat (6) @(posedge aclk);
   endtask

   task automatic set_c(input logic [7:0] m);
      contact_req <= m;
      settle();
   endtask

   // Each channel moves at the rising edge where its valid meets ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic done, ta, tw;
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid;
         last_resp = s_axi_bresp;
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a);
      logic done, ta;
      done = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid;
         rdat = s_axi_rdata;
         last_resp = s_axi_rresp;
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic st_bit(input int b, input logic e);
      rd(OFS_STATUS);
      check({31'h0, rdat[b]}, {31'h0, e});
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      end_of_test();
   end

   initial begin
      // Weight, {stable, load, overflow, sequence error}, expected drives
      rows = '{'{32'sd0, 4'b1000, 9'b100010100},
         '{32'sd50, 4'b0000, 9'b100010000},
         '{32'sd51, 4'b0100, 9'b000010010},
         '{32'sd699, 4'b0010, 9'b000010010},
         '{32'sd700, 4'b0001, 9'b010010001},
         '{32'sd900, 4'b0000, 9'b011010000},
         '{32'sd901, 4'b0000, 9'b011000000},
         '{32'sd980, 4'b0000, 9'b011100000},
         '{32'sd1099, 4'b1000, 9'b011100100},
         '{32'sd1100, 4'b0000, 9'b011101000}};
      repeat (16) @(posedge aclk);
      check({23'h0, oc_drive}, 32'h0);
      check({28'h0, evt}, 32'h0);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_CTRL);
      check(rdat, CTRL_RST);
      rd(OFS_INSEL);
      check(rdat, {20'h0, INSEL_RST});
      rd(8'h40);
      check({30'h0, last_resp}, {30'h0, RESP_SLVERR});
      wr(8'h02, 32'h1);
      check({30'h0, last_resp}, {30'h0, RESP_SLVERR});
      wr(OFS_FINAL, 32'd1000);
      check({30'h0, last_resp}, {30'h0, RESP_OKAY});
      wr(OFS_SP1, 32'd300);
      wr(OFS_SP2, 32'd100);
      wr(OFS_CPS, 32'd20);
      wr(OFS_NEARZERO, 32'd50);
      wr(OFS_UPPER, 32'd1100);
      wr(OFS_LOWER, 32'd900);
      foreach (rows[i]) begin
         raw_weight <= rows[i].weight;
         {motion_stable, load_error, overflow_error, seq_error_ind} <=
            rows[i].status_in;
         settle();
         check({23'h0, relay_on}, {23'h0, rows[i].expect_out});
      end
      // Strict upper limit
      wr(OFS_CTRL, 32'h1 << CTL_UPPER_STRICT);
      settle();
      check({31'h0, oc_drive.upper_limit}, 32'h0);
      raw_weight <= 32'sd1101;
      settle();
      check({31'h0, oc_drive.upper_limit}, 32'h1);
      // Limits only while judging; pins: acc cmd, acc clear, start, judge
      wr(OFS_CTRL, 32'h1 << CTL_LIM_JUDGE);
      wr(OFS_INSEL, 32'h0000_0d0a);
      raw_weight <= 32'sd1200;
      settle();
      check({31'h0, oc_drive.upper_limit}, 32'h0);
      set_c(8'h08);
      check({31'h0, oc_drive.upper_limit}, 32'h1);
      set_c(8'h00);
      wr(OFS_CTRL, (32'h1 << CTL_LIM_JUDGE) | (32'h1 << CTL_SEQ_MODE));
      set_c(8'h08);
      check({31'h0, oc_drive.upper_limit}, 32'h0);
      set_c(8'h00);
      // Accumulate gross, then clear, each edge exactly once
      wr(OFS_CTRL, 32'h0);
      raw_weight <= 32'sd300;
      set_c(8'h01);
      set_c(8'h00);
      check(n_acc, 32'd1);
      check(accum_value, 32'd300);
      set_c(8'h02);
      set_c(8'h00);
      check(n_clr, 32'd1);
      set_c(8'h04);
      set_c(8'h00);
      check(n_seq, 32'd1);
      wr(OFS_INSEL, 32'h0000_0cca);
      set_c(8'h04);
      set_c(8'h00);
      check(n_seq, 32'd17);
      // Hold freezes comparisons
      wr(OFS_INSEL, 32'h0);
      raw_weight <= 32'sd0;
      set_c(8'h04);
      raw_weight <= 32'sd500;
      settle();
      check({31'h0, hold_indicator}, 32'h1);
      check({31'h0, oc_drive.near_zero}, 32'h1);
      set_c(8'h00);
      check({31'h0, oc_drive.near_zero}, 32'h0);
      // Feed on two pins falls back to hold
      wr(OFS_CTRL, 32'h1 << CTL_EXT_FEED);
      wr(OFS_INSEL, 32'h0000_002d);
      set_c(8'h02);
      check({31'h0, hold_indicator}, 32'h1);
      check({31'h0, discharge_mode}, 32'h0);
      set_c(8'h00);
      wr(OFS_INSEL, 32'h0000_0005);
      set_c(8'h01);
      check({31'h0, discharge_mode}, 32'h1);
      set_c(8'h00);
      check({31'h0, discharge_mode}, 32'h0);
      wr(OFS_CTRL, 32'h1 << CTL_DISCHARGE);
      settle();
      check({31'h0, discharge_mode}, 32'h1);
      wr(OFS_CTRL, 32'h1 << CTL_SEQ_MODE);
      set_c(8'h08);
      check({31'h0, hold_indicator}, 32'h0);
      set_c(8'h00);
      // Gross/net switching, edge then level mode
      wr(OFS_CTRL, 32'h0);
      set_c(8'h80);
      st_bit(ST_DISP_NET, 1'b1);
      set_c(8'h00);
      st_bit(ST_DISP_NET, 1'b0);
      wr(OFS_CTRL, 32'h1 << CTL_GN_LEVEL);
      set_c(8'h80);
      st_bit(ST_DISP_NET, 1'b1);
      set_c(8'h00);
      st_bit(ST_DISP_NET, 1'b0);
      // Tare only while stable, then only up to capacity
      wr(OFS_CTRL, 32'h1 << CTL_TARE_STABLE);
      raw_weight <= 32'sd300;
      motion_stable <= 1'b0;
      set_c(8'h20);
      set_c(8'h00);
      st_bit(ST_TARE_ACT, 1'b0);
      motion_stable <= 1'b1;
      set_c(8'h20);
      set_c(8'h00);
      st_bit(ST_TARE_ACT, 1'b1);
      rd(OFS_TARE);
      check(rdat, 32'd300);
      set_c(8'h10);
      set_c(8'h00);
      st_bit(ST_TARE_ACT, 1'b0);
      wr(OFS_CTRL, 32'h1 << CTL_TARE_RANGE);
      set_c(8'h20);
      set_c(8'h00);
      st_bit(ST_TARE_ACT, 1'b0);
      wr(OFS_CAPACITY, 32'd500);
      set_c(8'h20);
      set_c(8'h00);
      st_bit(ST_TARE_ACT, 1'b1);
      set_c(8'h10);
      set_c(8'h00);
      // Zeroing outside and inside the zero range
      wr(OFS_CTRL, 32'h0);
      wr(OFS_DZRANGE, 32'd10);
      raw_weight <= 32'sd50;
      set_c(8'h40);
      set_c(8'h00);
      st_bit(ST_ZERO_ALARM, 1'b1);
      check({31'h0, oc_drive.weight_error}, 32'h1);
      raw_weight <= 32'sd5;
      set_c(8'h40);
      set_c(8'h00);
      rd(OFS_GROSS);
      check(rdat, 32'h0);
      st_bit(ST_ZERO_ALARM, 1'b0);
      check({31'h0, oc_drive.weight_error}, 32'h0);
      raw_weight <= 32'sd50;
      set_c(8'h40);
      set_c(8'h00);
      st_bit(ST_ZERO_ALARM, 1'b1);
      wr(OFS_STATUS, 32'h1 << ST_ZERO_ALARM);
      st_bit(ST_ZERO_ALARM, 1'b0);
      end_of_test();
   end
endmodule
